// ---- afe_pkg.sv ----
package afe_pkg;

	// ************************************************************
	// Register map and field layout
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOOP = 8'h04;
	localparam logic [7:0] OFS_GAIN = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_ERROR = 8'h10;
	localparam int CTRL_W = 7;
	localparam int LOOP_W = 9;
	localparam int GAIN_W = 8;
	localparam logic [6:0] CTRL_RST = 7'h60;
	localparam logic [8:0] LOOP_RST = 9'h000;
	localparam logic [7:0] GAIN_RST = 8'h00;
	localparam int ERR_FLD_LSB = 0;
	localparam int DAC_FLD_LSB = 16;
	localparam int STATE_FLD_LSB = 1;
	localparam int LINE_FLD_LSB = 8;

	// ************************************************************
	// Converter and loop constants
	// ************************************************************
	localparam int CODE_W = 10;
	localparam int DAC_W = 16;
	localparam logic [9:0] CLAMP_BASE = 10'h00E;
	localparam logic [3:0] OB_FIRST = 4'h5;
	localparam logic [3:0] OB_LAST = 4'hC;
	localparam int OB_AVG_SHIFT = 3;
	localparam logic [9:0] LEADIN_THRESH = 10'h010;
	localparam int LAT_CDS = 10;
	localparam int LAT_ADC = 9;
	localparam logic [2:0] LEADIN_SHIFT_BASE = 3'h2;

	typedef struct packed {
		logic sample_mode;
		logic out_enable;
		logic top_bit_invert;
		logic low_bits_invert;
		logic code_format_select;
		logic test_select_a;
		logic low_power_wait;
	} ctrl_t;

	typedef struct packed {
		logic [4:0] clamp_code;
		logic [1:0] leadin_exit_delay_sel;
		logic [1:0] leadin_gain_sel;
	} loop_cfg_t;

	typedef enum logic [1:0] {
		LOOP_NORMAL = 2'b00,
		LOOP_LEADIN = 2'b01,
		LOOP_EXIT = 2'b11
	} loop_state_t;

	function automatic logic [9:0] to_gray(input logic [9:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [2:0] leadin_shift(input logic [1:0] sel);
		return LEADIN_SHIFT_BASE + {1'b0, sel};
	endfunction

	function automatic logic [3:0] exit_lines(input logic [1:0] sel);
		return 4'h1 << sel;
	endfunction

	function automatic logic [9:0] clamp_value(input logic [4:0] code);
		return CLAMP_BASE + {4'h0, code, 1'b0};
	endfunction

endpackage

// ---- afe_offset_output.sv ----
`timescale 1ns/1ps
module afe_offset_output
	import afe_pkg::*;
#(
	parameter logic [9:0] ERR_LIMIT = 10'h040
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	input wire logic conversion_clock,
	input wire logic [CODE_W-1:0] conv_code_in,
	input wire logic optical_black_pulse,
	input wire logic pre_blank_in,
	output logic [CODE_W-1:0] data_out,
	output logic [CODE_W-1:0] data_oe,
	output logic sample_isolate,
	output logic [DAC_W-1:0] dac_step,
	output logic dac_charge_down,
	output logic dac_strobe,
	output logic leadin_active
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	generate
		if (ERR_LIMIT == 10'h000)
		begin : g_bad_limit
			$error("ERR_LIMIT must be nonzero");
		end
	endgenerate

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
	logic obp_s1_reg, obp_s2_reg, obp_s3_reg;
	logic pb_s1_reg, pb_s2_reg;
	logic [CODE_W-1:0] code_s1_reg, code_s2_reg;
	logic conv_en, ob_start;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			clk_s1_reg <= 1'b0;
			clk_s2_reg <= 1'b0;
			clk_s3_reg <= 1'b0;
			obp_s1_reg <= 1'b0;
			obp_s2_reg <= 1'b0;
			obp_s3_reg <= 1'b0;
			pb_s1_reg <= 1'b0;
			pb_s2_reg <= 1'b0;
			code_s1_reg <= 10'h000;
			code_s2_reg <= 10'h000;
		end
		else
		begin
			clk_s1_reg <= conversion_clock;
			clk_s2_reg <= clk_s1_reg;
			clk_s3_reg <= clk_s2_reg;
			obp_s1_reg <= optical_black_pulse;
			obp_s2_reg <= obp_s1_reg;
			obp_s3_reg <= obp_s2_reg;
			pb_s1_reg <= pre_blank_in;
			pb_s2_reg <= pb_s1_reg;
			code_s1_reg <= conv_code_in;
			code_s2_reg <= code_s1_reg;
		end
	end

	// Rising conversion clock seen two cycles late; codes move with it
	assign conv_en = clk_s2_reg & ~clk_s3_reg;
	assign ob_start = obp_s2_reg & ~obp_s3_reg;

	// ************************************************************
	// Register file
	// ************************************************************
	ctrl_t ctrl_reg;
	loop_cfg_t loop_reg;
	logic [GAIN_W-1:0] gain_reg;
	logic gain_change;
	loop_state_t state_reg;
	logic signed [10:0] err_reg;
	logic [15:0] line_cnt_reg;

	assign gain_change = wr_en && addr == OFS_GAIN
		&& wr_data[GAIN_W-1:0] != gain_reg;

	// Modes come only from software; pre-blank stays a pin
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctrl_reg <= CTRL_RST;
			loop_reg <= LOOP_RST;
			gain_reg <= GAIN_RST;
		end
		else if (wr_en)
		begin
			if (addr == OFS_CTRL)
				ctrl_reg <= wr_data[CTRL_W-1:0];
			if (addr == OFS_LOOP)
				loop_reg <= wr_data[LOOP_W-1:0];
			if (addr == OFS_GAIN)
				gain_reg <= wr_data[GAIN_W-1:0];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rd_data <= 32'h0000_0000;
		else if (rd_en)
		begin
			unique case (addr)
				OFS_CTRL: rd_data <= {25'h0, ctrl_reg};
				OFS_LOOP: rd_data <= {23'h0, loop_reg};
				OFS_GAIN: rd_data <= {24'h0, gain_reg};
				OFS_STATUS: rd_data <= {line_cnt_reg, 7'h00, pb_s2_reg,
					4'h0, state_reg, 1'b0, leadin_active};
				OFS_ERROR: rd_data <= {dac_step, 5'h0, err_reg};
				default: rd_data <= 32'h0000_0000;
			endcase
		end
		else
			rd_data <= 32'h0000_0000;
	end

	// ************************************************************
	// Optical-black window and error
	// ************************************************************
	logic [3:0] ob_cnt_reg;
	logic ob_run_reg;
	logic [12:0] ob_sum_reg;
	logic line_done_reg;
	logic [9:0] clamp10;
	logic [9:0] avg;
	logic signed [10:0] err_now;
	logic [9:0] err_mag, err_lim, last_mag_reg;

	assign clamp10 = clamp_value(loop_reg.clamp_code);
	assign avg = ob_sum_reg[12:OB_AVG_SHIFT];
	assign err_now = $signed({1'b0, avg}) - $signed({1'b0, clamp10});
	assign err_mag = err_now[10] ? 10'(-err_now) : err_now[9:0];
	assign err_lim = (err_mag > ERR_LIMIT) ? ERR_LIMIT : err_mag;

	// Samples counted on conversion edges; a new pulse restarts the window
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ob_cnt_reg <= 4'h0;
			ob_run_reg <= 1'b0;
			ob_sum_reg <= 13'h0000;
			line_done_reg <= 1'b0;
		end
		else
		begin
			line_done_reg <= 1'b0;
			if (ob_start)
			begin
				ob_cnt_reg <= 4'h0;
				ob_run_reg <= 1'b1;
				ob_sum_reg <= 13'h0000;
			end
			else if (ob_run_reg && conv_en)
			begin
				ob_cnt_reg <= ob_cnt_reg + 4'h1;
				if (ob_cnt_reg + 4'h1 >= OB_FIRST)
					ob_sum_reg <= ob_sum_reg + {3'h0, code_s2_reg};
				if (ob_cnt_reg + 4'h1 == OB_LAST)
				begin
					ob_run_reg <= 1'b0;
					line_done_reg <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Loop gain state machine
	// ************************************************************
	logic [3:0] exit_cnt_reg;

	// A gain change beats a same-cycle exit decision
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_reg <= LOOP_NORMAL;
			exit_cnt_reg <= 4'h0;
		end
		else if (gain_change)
		begin
			state_reg <= LOOP_LEADIN;
			exit_cnt_reg <= 4'h0;
		end
		else if (line_done_reg)
		begin
			unique case (state_reg)
				LOOP_NORMAL: state_reg <= LOOP_NORMAL;
				LOOP_LEADIN:
				begin
					if (err_mag <= LEADIN_THRESH)
					begin
						state_reg <= LOOP_EXIT;
						exit_cnt_reg <= exit_lines(loop_reg.leadin_exit_delay_sel);
					end
				end
				LOOP_EXIT:
				begin
					if (err_mag > LEADIN_THRESH)
						state_reg <= LOOP_LEADIN;
					else if (exit_cnt_reg == 4'h1)
						state_reg <= LOOP_NORMAL;
					else
						exit_cnt_reg <= exit_cnt_reg - 4'h1;
				end
				default: state_reg <= LOOP_NORMAL;
			endcase
		end
	end

	// ************************************************************
	// Current DAC step, one per line
	// ************************************************************
	logic [2:0] shift_now;

	assign shift_now = (state_reg == LOOP_NORMAL) ? 3'h0
		: leadin_shift(loop_reg.leadin_gain_sel);

	// Multiplying by a shift keeps the step exact and cheap
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			dac_step <= 16'h0000;
			dac_charge_down <= 1'b0;
			dac_strobe <= 1'b0;
			err_reg <= 11'h000;
			last_mag_reg <= 10'h000;
			line_cnt_reg <= 16'h0000;
			leadin_active <= 1'b0;
		end
		else
		begin
			dac_strobe <= line_done_reg;
			leadin_active <= state_reg != LOOP_NORMAL;
			if (line_done_reg)
			begin
				dac_step <= {6'h00, err_lim} << shift_now;
				dac_charge_down <= err_now[10];
				err_reg <= err_now;
				last_mag_reg <= err_mag;
				line_cnt_reg <= line_cnt_reg + 16'h0001;
			end
		end
	end

	// ************************************************************
	// Output pipeline and formatting
	// ************************************************************
	logic [CODE_W-1:0] pipe_reg [LAT_CDS-1];
	logic [CODE_W-1:0] tap, fmt, inv_mask, test_cnt_reg;
	logic test_active;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < LAT_CDS - 1; i++)
				pipe_reg[i] <= 10'h000;
		end
		else if (conv_en)
		begin
			pipe_reg[0] <= code_s2_reg;
			for (int i = 1; i < LAT_CDS - 1; i++)
				pipe_reg[i] <= pipe_reg[i-1];
		end
	end

	assign tap = ctrl_reg.sample_mode ? pipe_reg[LAT_CDS-2]
		: pipe_reg[LAT_ADC-2];
	assign fmt = ctrl_reg.code_format_select ? to_gray(tap) : tap;
	assign inv_mask = {ctrl_reg.top_bit_invert,
		{9{ctrl_reg.low_bits_invert}}};
	assign test_active = ctrl_reg.test_select_a & ~ctrl_reg.low_power_wait;

	// Test pattern is a ramp; it ignores format and pre-blank
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			data_out <= 10'h000;
			test_cnt_reg <= 10'h000;
		end
		else if (conv_en)
		begin
			test_cnt_reg <= test_cnt_reg + 10'h001;
			if (test_active)
				data_out <= test_cnt_reg;
			else if (pb_s2_reg)
				data_out <= clamp10;
			else
				data_out <= fmt ^ inv_mask;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			data_oe <= 10'h000;
			sample_isolate <= 1'b0;
		end
		else
		begin
			data_oe <= {CODE_W{ctrl_reg.out_enable
				& ~ctrl_reg.low_power_wait}};
			sample_isolate <= pb_s2_reg;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	chk_standby_hiz: assert property (
		ctrl_reg.low_power_wait |=> data_oe == 10'h000)
		else $error("outputs driven in standby");

	chk_preblank_clamp: assert property (
		conv_en && pb_s2_reg && !test_active
		|=> data_out == $past(clamp10))
		else $error("pre-blank output not clamp level");

	chk_gray_plain: assert property (
		conv_en && !test_active && !pb_s2_reg && inv_mask == 10'h000
		&& ctrl_reg.code_format_select
		|=> data_out == to_gray($past(tap)))
		else $error("gray code wrong");

	chk_binary_plain: assert property (
		conv_en && !test_active && !pb_s2_reg && inv_mask == 10'h000
		&& !ctrl_reg.code_format_select |=> data_out == $past(tap))
		else $error("binary code wrong");

	chk_top_invert: assert property (
		conv_en && !test_active && !pb_s2_reg && inv_mask == 10'h200
		|=> data_out == ($past(fmt) ^ 10'h200))
		else $error("top bit inversion wrong");

	chk_leadin_entry: assert property (
		gain_change |=> state_reg == LOOP_LEADIN ##1 leadin_active)
		else $error("gain change missed lead-in");

	chk_leadin_hold: assert property (
		line_done_reg && state_reg == LOOP_LEADIN && err_mag > 10'h010
		&& !gain_change |=> state_reg == LOOP_LEADIN)
		else $error("lead-in left above threshold");

	chk_exit_delay: assert property (
		line_done_reg && state_reg == LOOP_LEADIN && err_mag <= 10'h010
		&& !gain_change |=> state_reg == LOOP_EXIT
		&& exit_cnt_reg == exit_lines($past(loop_reg.leadin_exit_delay_sel)))
		else $error("exit delay load wrong");

	chk_step_scale: assert property (
		line_done_reg |=> dac_strobe
		&& dac_step == ({6'h00, $past(err_lim)} << $past(shift_now)))
		else $error("dac step scaling wrong");

	chk_err_clip: assert property (
		dac_strobe |-> dac_step <= ({6'h00, ERR_LIMIT} << 5))
		else $error("dac step exceeds clip");

	chk_isolate: assert property (
		pb_s2_reg |=> sample_isolate)
		else $error("sampling not isolated");

endmodule

// ---- cdsp_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// Signal processor side: conversion clock source, code capture
// ************************************************************
module cdsp_model
	import afe_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [CODE_W-1:0] data_out,
	input wire logic [CODE_W-1:0] data_oe,
	output logic conversion_clock,
	output logic [CODE_W-1:0] captured
);
	logic [1:0] div_reg;
	initial
	begin
		div_reg = 2'h0;
		conversion_clock = 1'b0;
		captured = 10'h000;
	end
	// Four cycles a phase keeps the pin above its sync margin
	always @(posedge sys_clk)
	begin
		div_reg <= div_reg + 2'h1;
		if (div_reg == 2'h3)
			conversion_clock <= ~conversion_clock;
	end
	// A released bus reads as the inverse of the last word, never held
	always @(posedge conversion_clock)
		captured <= (data_oe == 10'h3FF) ? data_out : ~captured;
endmodule

// ---- afe_offset_output_tb_top.sv ----
`timescale 1ns/1ps
module afe_offset_output_tb_top
	import afe_pkg::*;
;
	logic sys_clk;
	logic rst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic [DATA_W-1:0] rd_data;
	logic conversion_clock;
	logic [CODE_W-1:0] conv_code_in;
	logic optical_black_pulse;
	logic pre_blank_in;
	logic [CODE_W-1:0] data_out;
	logic [CODE_W-1:0] data_oe;
	logic sample_isolate;
	logic [DAC_W-1:0] dac_step;
	logic dac_charge_down;
	logic dac_strobe;
	logic leadin_active;
	logic [CODE_W-1:0] captured;
	logic [CODE_W-1:0] snap;
	logic [16:0] dac_q[$];
	logic [31:0] rnd;
	int err_total;
	int check_count;

	afe_offset_output afe_offset_output_inst (
		.sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.conversion_clock(conversion_clock), .conv_code_in(conv_code_in),
		.optical_black_pulse(optical_black_pulse),
		.pre_blank_in(pre_blank_in), .data_out(data_out),
		.data_oe(data_oe), .sample_isolate(sample_isolate),
		.dac_step(dac_step), .dac_charge_down(dac_charge_down),
		.dac_strobe(dac_strobe), .leadin_active(leadin_active)
	);
	cdsp_model cdsp_model_inst (
		.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
		.conversion_clock(conversion_clock), .captured(captured)
	);

	// ************************************************************
	// Clock, comparison and closing
	// ************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// ************************************************************
	// Drivers
	// ************************************************************
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		check(nm, rd_data, exp);
	endtask

	task convs(input int n);
		repeat (n) @(posedge conversion_clock);
		repeat (4) @(posedge sys_clk);
	endtask

	// Latency is ten edges at most, so fourteen leaves margin
	task fmt(input logic [6:0] c, input logic [9:0] v, input logic [9:0] e);
		wr(OFS_CTRL, {25'h0, c});
		@(posedge sys_clk);
		conv_code_in <= v;
		convs(14);
		check("code", captured, e);
	endtask

	task line(input logic [9:0] v, input logic [16:0] e);
		dac_q.push_back(e);
		@(posedge sys_clk);
		conv_code_in <= v;
		convs(2);
		@(posedge sys_clk);
		optical_black_pulse <= 1'b1;
		repeat (4) @(posedge sys_clk);
		optical_black_pulse <= 1'b0;
		convs(14);
		check("dac_pending", dac_q.size(), 0);
	endtask

	always @(posedge sys_clk)
		if (dac_strobe === 1'b1)
		begin
			if (dac_q.size() == 0)
				check("dac_extra", 1, 0);
			else
				check("dac", {dac_charge_down, dac_step}, dac_q.pop_front());
		end

	initial
	begin
		repeat (30000) @(posedge sys_clk);
		err_total++;
		$display("watchdog expired");
		end_sim;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		rst = 1'b1;
		addr = 8'h00;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		conv_code_in = 10'h000;
		optical_black_pulse = 1'b0;
		pre_blank_in = 1'b0;
		err_total = 0;
		check_count = 0;
		rnd = 32'h28;
		repeat (12) @(posedge sys_clk);
		check("oe_reset", data_oe, 10'h000);
		rst <= 1'b0;
		rd(OFS_CTRL, 32'h60, "ctrl_reset");
		rd(8'h14, 32'h0, "unmapped");
		check("oe_on", data_oe, 10'h3FF);
		$display("test reset done");
		fmt(7'h60, 10'h1FF, 10'h1FF);
		fmt(7'h64, 10'h1FF, 10'h100);
		fmt(7'h64, 10'h200, 10'h300);
		fmt(7'h70, 10'h005, 10'h205);
		fmt(7'h68, 10'h005, 10'h1FA);
		fmt(7'h78, 10'h2AA, 10'h155);
		fmt(7'h7C, 10'h200, 10'h0FF);
		fmt(7'h20, 10'h3FF, 10'h3FF);
		for (int i = 0; i < 4; i++)
		begin
			rnd = xs(rnd);
			fmt(7'h64, rnd[9:0], rnd[9:0] ^ (rnd[9:0] >> 1));
		end
		$display("test formats done");
		// Clamp code 3 gives a clamp level of 20
		wr(OFS_LOOP, 32'h30);
		@(posedge sys_clk);
		pre_blank_in <= 1'b1;
		fmt(7'h78, 10'h2AA, 10'h014);
		check("isolate", sample_isolate, 1'b1);
		wr(OFS_CTRL, 32'h62);
		convs(2);
		snap = captured;
		convs(1);
		check("test_ramp", captured === snap, 1'b0);
		pre_blank_in <= 1'b0;
		wr(OFS_CTRL, 32'h61);
		repeat (3) @(posedge sys_clk);
		check("oe_standby", data_oe, 10'h000);
		wr(OFS_CTRL, 32'h40);
		repeat (3) @(posedge sys_clk);
		check("oe_off", data_oe, 10'h000);
		wr(OFS_CTRL, 32'h60);
		$display("test output stage done");
		line(10'h024, 17'h00010);
		line(10'h009, 17'h1000B);
		line(10'h12C, 17'h00040);
		rnd = xs(rnd);
		line(10'h014 + {4'h0, rnd[5:0]}, {11'h0, rnd[5:0]});
		$display("test loop step done");
		for (int s = 0; s < 4; s++)
		begin
			wr(OFS_LOOP, 32'h30 | (s << 2) | s);
			wr(OFS_GAIN, 32'h10 + s);
			repeat (3) @(posedge sys_clk);
			check("leadin_on", leadin_active, 1'b1);
			line(10'h028, 17'h14 << (2 + s));
			check("leadin_hold", leadin_active, 1'b1);
			for (int i = 0; i <= (1 << s); i++)
			begin
				line(10'h014, 17'h0);
				check("leadin_exit", leadin_active, i < (1 << s));
			end
		end
		$display("test lead-in done");
		end_sim;
	end
endmodule
